// ### include/bcduc_pkg.sv
package bcduc_pkg;
   // Width of the count.
   localparam int COUNT_W = 4;
   // Terminal counts of the two variants.
   localparam logic [3:0] DECADE_MAX = 4'h9;
   localparam logic [3:0] BINARY_MAX = 4'hf;
   localparam logic [3:0] COUNT_ZERO = 4'h0;
   // Reset value of the count.
   localparam logic [3:0] COUNT_RST  = 4'h0;

   // Raw pin inputs of the counter.
   typedef struct packed {
      logic       up_clk;
      logic       down_clk;
      logic       clear;
      logic       load_n;
      logic [3:0] preset;
   } bcduc_pins_t;
endpackage

// ### src/bcduc_sync.sv
`timescale 1ns/1ns
module bcduc_sync #(
   parameter int           W    = 8,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset.
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Raw and synchronised levels.
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   // Two flip-flops per bit; stage1 is read only by the second stage.
   // Both stages reset to the idle level of the pins, so the logic behind
   // sees no false edge or load when reset is released.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stage1   <= INIT;
         sync_out <= INIT;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // bcduc_sync

// ### src/bcduc_counter.sv
// Operation
// - Holds a four-bit count, decade or binary depending on variant.
// - Without clear or load, count changes only on a rising edge of either count clock.
// - Up clock rising while down clock high adds exactly one.
// - Down clock rising while up clock high, and not rising in the same cycle, subtracts exactly one.
// - Clear forces count to zero, blocks load, ignores both clocks.
// - Load low without clear copies preset inputs regardless of clocks.
// - Carry and borrow outputs rest high, low only at terminal count.
// - At maximum count carry follows the up clock while it is low.
// - At zero count borrow follows the down clock while it is low.
// - Decade variant terminal state nine makes carry copy the up clock.
// - Carry and borrow may clock the next stage; cascades ripple.
// - A clock low through clear or load counts on its next rise.
`timescale 1ns/1ns
module bcduc_counter #(
   parameter bit DECADE = 1'b1
) (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Count clocks, clear and load pins.
   input  wire logic       up_count_clock,
   input  wire logic       down_count_clock,
   input  wire logic       master_clear,
   input  wire logic       load_strobe_n,
   input  wire logic [3:0] preset_inputs,
   // Count and cascade outputs.
   output logic      [3:0] count_outputs,
   output logic            carry_out_n,
   output logic            borrow_out_n
);
   localparam logic [3:0] MAX_CNT =
      DECADE ? bcduc_pkg::DECADE_MAX : bcduc_pkg::BINARY_MAX;

   // Idle pin levels: both clocks high, no clear, no load, preset zero.
   localparam bcduc_pkg::bcduc_pins_t PINS_IDLE = '{up_clk: 1'b1,
      down_clk: 1'b1, clear: 1'b0, load_n: 1'b1,
      preset: bcduc_pkg::COUNT_RST};

   bcduc_pkg::bcduc_pins_t raw;
   bcduc_pkg::bcduc_pins_t pins;
   logic [3:0] count;
   logic [3:0] next_count;
   logic       up_prev;
   logic       down_prev;
   logic       next_carry_n;
   logic       next_borrow_n;
   logic       up_rise;
   logic       down_rise;

   // Every pin crosses into the clock domain before any logic reads it.
   assign raw = '{up_clk: up_count_clock, down_clk: down_count_clock,
                  clear: master_clear, load_n: load_strobe_n,
                  preset: preset_inputs};

   bcduc_sync #(
      .W    ($bits(bcduc_pkg::bcduc_pins_t)),
      .INIT (PINS_IDLE)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (raw),
      .sync_out (pins)
   );

   // Edge detection on the synchronised clocks.
   assign up_rise   = pins.up_clk & ~up_prev;
   assign down_rise = pins.down_clk & ~down_prev;

   // Next count: clear, then load, then counting; the edge history keeps
   // tracking through clear and load so a low clock counts on its rise.
   always_comb begin
      next_count = count;
      if (pins.clear) begin
         next_count = bcduc_pkg::COUNT_ZERO;
      end else if (!pins.load_n) begin
         next_count = pins.preset;
      end else if (up_rise && pins.down_clk) begin
         if (count >= MAX_CNT) begin
            next_count = bcduc_pkg::COUNT_ZERO;
         end else begin
            next_count = count + 4'h1;
         end
      end else if (down_rise && pins.up_clk) begin
         if (count == bcduc_pkg::COUNT_ZERO || count > MAX_CNT) begin
            next_count = MAX_CNT;
         end else begin
            next_count = count - 4'h1;
         end
      end
   end

   // Terminal outputs copy the low phase of the clock; clear hides carry.
   // They lag the pin by the synchroniser and their own output register, which a ripple cascade tolerates.
   always_comb begin
      next_carry_n  = 1'b1;
      next_borrow_n = 1'b1;
      if (next_count == MAX_CNT && !pins.up_clk && !pins.clear) begin
         next_carry_n = 1'b0;
      end
      if (next_count == bcduc_pkg::COUNT_ZERO && !pins.down_clk) begin
         next_borrow_n = 1'b0;
      end
   end

   // State registers.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count        <= bcduc_pkg::COUNT_RST;
         up_prev      <= 1'b1;
         down_prev    <= 1'b1;
         carry_out_n  <= 1'b1;
         borrow_out_n <= 1'b1;
      end else begin
         count        <= next_count;
         up_prev      <= pins.up_clk;
         down_prev    <= pins.down_clk;
         carry_out_n  <= next_carry_n;
         borrow_out_n <= next_borrow_n;
      end
   end

   assign count_outputs = count;

   // Qualified count events, used by the up step check up_seq_a and the down wrap check down_wrap_a.
   sequence up_edge_s;
      up_rise && pins.down_clk && pins.load_n && !pins.clear;
   endsequence

   sequence down_edge_s;
      down_rise && pins.up_clk && pins.load_n && !pins.clear;
   endsequence

   // Checks.
   // The down wrap lands on the variant's own maximum.
   down_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      down_edge_s ##0 (count == 4'h0) |=> count == MAX_CNT)
      else $error("down count did not wrap");
   // The up step built from the named event.
   up_seq_a: assert property (@(posedge sys_clk) disable iff (rst)
      up_edge_s ##0 (count < MAX_CNT) |=> count == $past(count) + 4'h1)
      else $error("up event did not add one");
   // Carry rests high away from its terminal condition.
   carry_rest_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(next_count != MAX_CNT || pins.up_clk || pins.clear)
      |-> carry_out_n)
      else $error("carry low without terminal count");
   // Borrow rests high away from its terminal condition.
   borrow_rest_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(next_count != 4'h0 || pins.down_clk) |-> borrow_out_n)
      else $error("borrow low without zero count");
   // Clear keeps carry high, whatever the up clock does.
   clear_carry_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(pins.clear) |-> carry_out_n)
      else $error("carry low during clear");
   // At maximum with the up clock low, carry must go low.
   carry_set_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(next_count == MAX_CNT && !pins.up_clk && !pins.clear)
      |-> !carry_out_n)
      else $error("carry not low at maximum");
   // Borrow only goes low at zero with the down clock low.
   borrow_only_a: assert property (@(posedge sys_clk) disable iff (rst)
      !borrow_out_n |-> $past(next_count == 4'h0 && !pins.down_clk))
      else $error("borrow low outside zero count");
   clear_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(pins.clear) |-> count == 4'h0)
      else $error("count not zero after clear");
   load_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(!pins.load_n && !pins.clear) |-> count == $past(pins.preset))
      else $error("load did not copy preset");
   up_step_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(up_rise && pins.down_clk && pins.load_n && !pins.clear)
       && $past(count) < MAX_CNT) |-> count == $past(count) + 4'h1)
      else $error("up count did not add one");
   down_step_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(down_rise && pins.up_clk && pins.load_n && !pins.clear)
       && $past(count) != 4'h0 && $past(count) <= MAX_CNT)
      |-> count == $past(count) - 4'h1)
      else $error("down count did not subtract one");
   no_edge_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(!up_rise && !down_rise && pins.load_n && !pins.clear)
      |-> $stable(count))
      else $error("count moved without an edge");
   up_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(up_rise && pins.down_clk && pins.load_n && !pins.clear)
       && $past(count) == MAX_CNT) |-> count == 4'h0)
      else $error("up count did not wrap");
   carry_low_a: assert property (@(posedge sys_clk) disable iff (rst)
      !carry_out_n |-> $past(next_count == MAX_CNT && !pins.up_clk))
      else $error("carry low outside terminal count");
   borrow_low_a: assert property (@(posedge sys_clk) disable iff (rst)
      $past(next_count == 4'h0 && !pins.down_clk) |-> !borrow_out_n)
      else $error("borrow not low at zero");
endmodule // bcduc_counter

// ### sim/bcduc_drv.sv
`timescale 1ns/1ns
module bcduc_drv (
   // Clock.
   input  wire logic       sys_clk,
   // Pins toward the counter.
   output logic            up_count_clock,
   output logic            down_count_clock,
   output logic            master_clear,
   output logic            load_strobe_n,
   output logic      [3:0] preset_inputs
);
   // Idle: both clocks high, no clear, no load.
   initial begin
      up_count_clock   = 1'b1;
      down_count_clock = 1'b1;
      master_clear     = 1'b0;
      load_strobe_n    = 1'b1;
      preset_inputs    = 4'h0;
   end

   // Sets every pin on a falling edge, then holds it for six cycles.
   // The hold covers the two-stage synchroniser plus the count edge.
   // Unused preset data toggles so that a stale value is never trusted.
   task automatic drv(input logic u, input logic dn, input logic c,
                      input logic l, input logic [3:0] v);
      @(negedge sys_clk);
      up_count_clock   = u;
      down_count_clock = dn;
      master_clear     = c;
      load_strobe_n    = l;
      preset_inputs    = l ? ~preset_inputs : v;
      repeat (6) @(negedge sys_clk);
   endtask
endmodule // bcduc_drv

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic       sys_clk = 1'b0;
   logic       rst     = 1'b1;
   logic       up_count_clock, down_count_clock, master_clear;
   logic       load_strobe_n, carry_out_n, borrow_out_n;
   logic [3:0] preset_inputs, count_outputs, count_bin;
   logic       carry_bin, borrow_bin;
   int         mismatches = 0;
   int         checks     = 0;

   // Free-running 50 MHz clock.
   always #10 sys_clk = ~sys_clk;

   bcduc_drv i_drv (.sys_clk(sys_clk), .up_count_clock(up_count_clock),
      .down_count_clock(down_count_clock), .master_clear(master_clear),
      .load_strobe_n(load_strobe_n), .preset_inputs(preset_inputs));
   bcduc_counter #(.DECADE(1'b1)) i_dut (.sys_clk(sys_clk), .rst(rst),
      .up_count_clock(up_count_clock), .down_count_clock(down_count_clock),
      .master_clear(master_clear), .load_strobe_n(load_strobe_n),
      .preset_inputs(preset_inputs), .count_outputs(count_outputs),
      .carry_out_n(carry_out_n), .borrow_out_n(borrow_out_n));
   bcduc_counter #(.DECADE(1'b0)) i_dut_bin (.sys_clk(sys_clk),
      .rst(rst), .up_count_clock(up_count_clock),
      .down_count_clock(down_count_clock), .master_clear(master_clear),
      .load_strobe_n(load_strobe_n), .preset_inputs(preset_inputs),
      .count_outputs(count_bin), .carry_out_n(carry_bin),
      .borrow_out_n(borrow_bin));

   // Compares one observed value with its expectation.
   task automatic chk(input string what, input logic [3:0] seen,
                      input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Checks count, carry and borrow together.
   task automatic st(input logic [3:0] q, input logic co, input logic bo);
      chk("count", count_outputs, q);
      chk("carry", {3'h0, carry_out_n}, {3'h0, co});
      chk("borrow", {3'h0, borrow_out_n}, {3'h0, bo});
   endtask

   // Checks the binary variant's count, carry and borrow.
   task automatic sb(input logic [3:0] q, input logic co, input logic bo);
      chk("bin count", count_bin, q);
      chk("bin carry", {3'h0, carry_bin}, {3'h0, co});
      chk("bin borrow", {3'h0, borrow_bin}, {3'h0, bo});
   endtask

   // Binary variant: carry at fifteen, wraps both ways through zero.
   task automatic t_bin();
      i_drv.drv(1, 1, 0, 0, 4'he);
      i_drv.drv(0, 1, 0, 1, 4'h0);
      sb(4'he, 1, 1);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      sb(4'hf, 1, 1);
      i_drv.drv(0, 1, 0, 1, 4'h0);
      sb(4'hf, 0, 1);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      sb(4'h0, 1, 1);
      i_drv.drv(1, 0, 0, 1, 4'h0);
      sb(4'h0, 1, 0);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      sb(4'hf, 1, 1);
   endtask

   // Up through nine: carry copies the low up clock, then wraps.
   task automatic t_up();
      i_drv.drv(1, 1, 0, 0, 4'h8);
      i_drv.drv(0, 1, 0, 1, 4'h0);
      st(4'h8, 1, 1);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      st(4'h9, 1, 1);
      i_drv.drv(0, 1, 0, 1, 4'h0);
      st(4'h9, 0, 1);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      st(4'h0, 1, 1);
   endtask

   // Down from zero: borrow copies the low down clock, then wraps.
   task automatic t_down();
      i_drv.drv(1, 0, 0, 1, 4'h0);
      st(4'h0, 1, 0);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      st(4'h9, 1, 1);
   endtask

   // Load and clear priorities, and a clock held low through a load.
   task automatic t_prio();
      i_drv.drv(0, 1, 0, 0, 4'h5);
      st(4'h5, 1, 1);
      i_drv.drv(0, 1, 0, 1, 4'h0);
      i_drv.drv(1, 1, 0, 1, 4'h0);
      st(4'h6, 1, 1);
      i_drv.drv(0, 1, 0, 0, 4'h3);
      i_drv.drv(1, 1, 0, 0, 4'h3);
      st(4'h3, 1, 1);
      i_drv.drv(1, 1, 1, 0, 4'ha);
      st(4'h0, 1, 1);
      i_drv.drv(0, 1, 1, 1, 4'h0);
      i_drv.drv(1, 1, 1, 1, 4'h0);
      st(4'h0, 1, 1);
      i_drv.drv(1, 1, 0, 1, 4'h0);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("Checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence; reset is released on a falling edge.
   initial begin
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      st(4'h0, 1, 1);
      repeat (6) @(negedge sys_clk);
      st(4'h0, 1, 1);
      sb(4'h0, 1, 1);
      t_up();
      t_down();
      t_prio();
      t_bin();
      summarize();
   end

   // Watchdog, several times the expected run length.
   initial begin
      #20000;
      mismatches++;
      summarize();
   end
endmodule // tb_top
